//--- core/svcr_pkg.sv
// constants and carrier types of the sync status and calibration register bank
// Overview of operation
// R1: coast input polarity reported read-only, 1 positive
// R2: status bit 2 reports clamp polarity
// R3: status bit 1 flags extra pulses in hsync
// R4: status bit 0 reads 1 while filter locked
// R5: 12-bit hsync per vsync count, split readable
// R6: host writes test regs with fixed values
// R7: test regs three and four read-only
// R8: host writes zero to unused hold bits
// R9: offset hold 0 runs, 1 freezes offsets
// R10: host runs one-time offset update sequence
// R11: offset settles within ten updates, host waits
// R12: host repeats one-time updates after mode change
// R13: host writes test regs five and six
// R14: green sync filter blocks pulses under 250ns
// R15: gear bit selects low oscillator range
// R16: host keeps gain register upper bits zero
// R17: gain hold 1 runs, 0 holds, reset 0
// R18: host runs one-time gain update sequence
// R19: gain matching settles within ten updates
// R20: gain enable 000 off, 110 on
// R21: count source follows sync input select
// R22: status reads harmless, writes there ignored
// R23: count captured coherently at each vsync
package svcr_pkg;

  localparam int unsigned SVCR_ADR_W = 10;
  localparam int unsigned SVCR_DAT_W = 32;
  localparam int unsigned SVCR_CNT_W = 12;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_STATUS = 8'h25;
  localparam logic [7:0] IDX_CNT_UPPER = 8'h26;
  localparam logic [7:0] IDX_CNT_LOWER = 8'h27;
  localparam logic [7:0] IDX_TEST_ONE = 8'h28;
  localparam logic [7:0] IDX_TEST_TWO = 8'h29;
  localparam logic [7:0] IDX_TEST_THREE = 8'h2a;
  localparam logic [7:0] IDX_TEST_FOUR = 8'h2b;
  localparam logic [7:0] IDX_OFFSET_HOLD = 8'h2c;
  localparam logic [7:0] IDX_TEST_FIVE = 8'h2d;
  localparam logic [7:0] IDX_TEST_SIX = 8'h2e;
  localparam logic [7:0] IDX_GREEN_FILT = 8'h34;
  localparam logic [7:0] IDX_GEAR = 8'h36;
  localparam logic [7:0] IDX_GAIN = 8'h3c;

  // field positions
  localparam int unsigned BIT_COAST_POL = 3;
  localparam int unsigned BIT_CLAMP_POL = 2;
  localparam int unsigned BIT_EXTRA_PULSE = 1;
  localparam int unsigned BIT_FILT_LOCK = 0;
  localparam int unsigned BIT_OFFSET_HOLD = 4;
  localparam int unsigned BIT_GREEN_FILT_EN = 2;
  localparam int unsigned BIT_GEAR_LOW = 0;
  localparam int unsigned BIT_GAIN_HOLD = 3;
  localparam int unsigned CNT_LOWER_LSB = 4;
  localparam int unsigned CNT_UPPER_LSB = 4;

  localparam logic [2:0] GAIN_EN_OFF = 3'h0;
  localparam logic [2:0] GAIN_EN_ON = 3'h6;

  // reset values and the count ceiling
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [11:0] RST_COUNT = 12'h000;
  localparam logic [11:0] COUNT_MAX = 12'hfff;

  // calibration settle bound in update intervals
  localparam logic [3:0] SETTLE_UPDATES = 4'ha;
  localparam logic [3:0] SETTLE_ZERO = 4'h0;
  localparam logic [3:0] SETTLE_STEP = 4'h1;

  // green sync pulse filter width
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned GREEN_MIN_NS = 250;
  localparam int unsigned GREEN_MIN_CYC_RAW =
    (GREEN_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned GREEN_MIN_CYC = (GREEN_MIN_CYC_RAW < 1) ? 1 : GREEN_MIN_CYC_RAW;
  localparam logic [3:0] GREEN_MIN_CNT = 4'(GREEN_MIN_CYC);
  localparam logic [3:0] GREEN_CNT_ZERO = 4'h0;
  localparam logic [3:0] GREEN_CNT_STEP = 4'h1;

  // sync processor levels arriving from outside the core clock
  typedef struct packed {
    logic coast_pol;
    logic clamp_pol;
    logic extra_pulse;
    logic filt_lock;
    logic hsync_raw;
    logic hsync_regen;
    logic vsync;
    logic green_sync;
  } svcr_pins_t;

  // calibration handshake with the converter side
  typedef struct packed {
    logic offset_run;
    logic gain_run;
    logic offset_settled;
    logic gain_settled;
  } svcr_cal_t;

endpackage

//--- core/svcr_line_counter.sv
// hsync per vsync counter with coherent capture at each vsync
module svcr_line_counter
  import svcr_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_sync_input_sel,
  input wire logic i_hsync_raw,
  input wire logic i_hsync_regen,
  input wire logic i_vsync,
  output logic [11:0] o_count
);

  typedef struct packed {
    logic hs_d;
    logic vs_d;
    logic [11:0] running;
    logic [11:0] captured;
  } svcr_lc_state_t;

  svcr_lc_state_t state;
  svcr_lc_state_t next_state;
  logic hs_sel;
  logic hs_rise;
  logic vs_rise;

  always_comb
  begin
    hs_sel = i_sync_input_sel ? i_hsync_regen : i_hsync_raw; // see R21
    hs_rise = hs_sel & ~state.hs_d;
    vs_rise = i_vsync & ~state.vs_d;
    next_state = state;
    next_state.hs_d = hs_sel;
    next_state.vs_d = i_vsync;
    if (vs_rise)
    begin
      // whole 12-bit value moves at once so both halves agree
      next_state.captured = state.running; // see R23
      next_state.running = hs_rise ? 12'(RST_COUNT + 12'h001) : RST_COUNT; // see R5
    end
    else if (hs_rise && state.running != COUNT_MAX)
    begin
      // saturate rather than wrap on a missing vsync
      next_state.running = 12'(state.running + 12'h001); // see R5
    end
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign o_count = state.captured;

endmodule // svcr_line_counter

//--- core/svcr_regs.sv
// sync status and calibration register bank on a classic wishbone slave
module svcr_regs
  import svcr_pkg::*;
#(
  // arbitrary contents of the read-only future-use test locations
  parameter logic [7:0] TEST_THREE_VALUE = 8'h00,
  parameter logic [7:0] TEST_FOUR_VALUE = 8'h00
)
(
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [9:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire svcr_pins_t i_pins,
  input wire logic i_sync_input_sel,
  input wire logic i_auto_offset_en,
  input wire logic i_offset_update,
  input wire logic i_gain_update,
  output logic o_green_sync_filt,
  output logic o_gear_low,
  output svcr_cal_t o_cal
);

  typedef struct packed {
    svcr_pins_t meta;
    svcr_pins_t pins;
    logic [7:0] test_one;
    logic [7:0] test_two;
    logic [7:0] offset_hold;
    logic [7:0] test_five;
    logic [7:0] test_six;
    logic [7:0] green_filt;
    logic [7:0] gear;
    logic [7:0] gain;
    logic ack;
    logic [31:0] rdata;
    logic [3:0] green_cnt;
    logic green_out;
    logic gear_out;
    logic [3:0] offset_cnt;
    logic [3:0] gain_cnt;
    svcr_cal_t cal;
  } svcr_state_t;

  svcr_state_t state;
  svcr_state_t next_state;
  logic [11:0] line_count;
  logic [7:0] idx;
  logic access;
  logic wr_strobe;
  logic offset_run;
  logic gain_run;

  // index of the addressed register
  function automatic logic [7:0] reg_index(input logic [9:0] adr);
    reg_index = adr[9:2];
  endfunction

  // true for every index the bank answers with real contents
  function automatic logic is_mapped(input logic [7:0] i);
    case (i)
      IDX_STATUS, IDX_CNT_UPPER, IDX_CNT_LOWER,
      IDX_TEST_ONE, IDX_TEST_TWO, IDX_TEST_THREE, IDX_TEST_FOUR,
      IDX_OFFSET_HOLD, IDX_TEST_FIVE, IDX_TEST_SIX,
      IDX_GREEN_FILT, IDX_GEAR, IDX_GAIN:
        is_mapped = 1'b1;
      default:
        is_mapped = 1'b0;
    endcase
  endfunction

  // counts update intervals while a loop runs, stops at the settle bound
  function automatic logic [3:0] settle_next(
    input logic run,
    input logic upd,
    input logic [3:0] cnt
  );
    if (!run)
    begin
      settle_next = SETTLE_ZERO;
    end
    else if (upd && cnt != SETTLE_UPDATES)
    begin
      settle_next = 4'(cnt + SETTLE_STEP);
    end
    else
    begin
      settle_next = cnt;
    end
  endfunction

  svcr_line_counter u_line_counter (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_sync_input_sel(i_sync_input_sel),
    .i_hsync_raw(state.pins.hsync_raw),
    .i_hsync_regen(state.pins.hsync_regen),
    .i_vsync(state.pins.vsync),
    .o_count(line_count)
  );

  // read multiplexer; status locations are pure reads with no side effects
  function automatic logic [7:0] read_byte(
    input logic [7:0] i,
    input svcr_state_t s,
    input logic [11:0] cnt
  );
    logic [7:0] v;
    v = RST_BYTE;
    case (i)
      IDX_STATUS:
      begin
        v[BIT_COAST_POL] = s.pins.coast_pol; // see R1
        v[BIT_CLAMP_POL] = s.pins.clamp_pol; // see R2
        v[BIT_EXTRA_PULSE] = s.pins.extra_pulse; // see R3
        v[BIT_FILT_LOCK] = s.pins.filt_lock; // see R4
      end
      IDX_CNT_UPPER:
        v = cnt[11:CNT_UPPER_LSB]; // see R5
      IDX_CNT_LOWER:
        v[7:CNT_LOWER_LSB] = cnt[CNT_UPPER_LSB-1:0]; // see R5
      IDX_TEST_ONE:
        v = s.test_one;
      IDX_TEST_TWO:
        v = s.test_two;
      IDX_TEST_THREE:
        v = TEST_THREE_VALUE; // see R7
      IDX_TEST_FOUR:
        v = TEST_FOUR_VALUE; // see R7
      IDX_OFFSET_HOLD:
        v = s.offset_hold;
      IDX_TEST_FIVE:
        v = s.test_five;
      IDX_TEST_SIX:
        v = s.test_six;
      IDX_GREEN_FILT:
        v = s.green_filt;
      IDX_GEAR:
        v = s.gear;
      IDX_GAIN:
        v = s.gain;
      default:
        v = RST_BYTE;
    endcase
    read_byte = v;
  endfunction

  always_comb
  begin
    next_state = state;

    // two-stage synchronisers; only the second stage is read below
    next_state.meta = i_pins;
    next_state.pins = state.meta;

    idx = reg_index(i_wb_adr);
    access = i_wb_cyc & i_wb_stb & ~state.ack;
    wr_strobe = access & i_wb_we & i_wb_sel[0];

    // one ack per request, dropped the cycle after
    next_state.ack = access;
    if (access)
    begin
      next_state.rdata = RST_WORD;
      if (!i_wb_we && is_mapped(idx))
      begin
        next_state.rdata[7:0] = read_byte(idx, state, line_count);
      end
    end

    // writes to status and read-only test locations fall through the case
    if (wr_strobe)
    begin
      case (idx)
        IDX_TEST_ONE:
          next_state.test_one = i_wb_dat[7:0];
        IDX_TEST_TWO:
          next_state.test_two = i_wb_dat[7:0];
        IDX_OFFSET_HOLD:
          next_state.offset_hold = i_wb_dat[7:0];
        IDX_TEST_FIVE:
          next_state.test_five = i_wb_dat[7:0];
        IDX_TEST_SIX:
          next_state.test_six = i_wb_dat[7:0];
        IDX_GREEN_FILT:
          next_state.green_filt = i_wb_dat[7:0];
        IDX_GEAR:
          next_state.gear = i_wb_dat[7:0];
        IDX_GAIN:
          next_state.gain = i_wb_dat[7:0];
        default:
          next_state.ack = access; // see R22
      endcase
    end

    // green sync path: a new level passes only once it has held long enough
    if (!state.green_filt[BIT_GREEN_FILT_EN])
    begin
      next_state.green_out = state.pins.green_sync;
      next_state.green_cnt = GREEN_CNT_ZERO;
    end
    else if (state.pins.green_sync == state.green_out)
    begin
      next_state.green_cnt = GREEN_CNT_ZERO;
    end
    else if (4'(state.green_cnt + GREEN_CNT_STEP) >= GREEN_MIN_CNT)
    begin
      next_state.green_out = state.pins.green_sync; // see R14
      next_state.green_cnt = GREEN_CNT_ZERO;
    end
    else
    begin
      // narrower pulses restart the count and never reach the output
      next_state.green_cnt = 4'(state.green_cnt + GREEN_CNT_STEP); // see R14
    end

    next_state.gear_out = state.gear[BIT_GEAR_LOW]; // see R15

    // offset loop runs only while enabled and not held
    offset_run = i_auto_offset_en & ~state.offset_hold[BIT_OFFSET_HOLD]; // see R9
    // gain hold has the opposite sense: 1 lets the loop run
    gain_run = (state.gain[2:0] == GAIN_EN_ON) & state.gain[BIT_GAIN_HOLD]; // see R17 R20
    next_state.cal.offset_run = offset_run;
    next_state.cal.gain_run = gain_run;

    next_state.offset_cnt = settle_next(offset_run, i_offset_update, state.offset_cnt); // see R11
    next_state.gain_cnt = settle_next(gain_run, i_gain_update, state.gain_cnt); // see R19
    next_state.cal.offset_settled = (next_state.offset_cnt == SETTLE_UPDATES); // see R11
    next_state.cal.gain_settled = (next_state.gain_cnt == SETTLE_UPDATES); // see R19
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      state <= '0;
      state.test_one <= RST_BYTE;
      state.test_two <= RST_BYTE;
      state.offset_hold <= RST_BYTE;
      state.test_five <= RST_BYTE;
      state.test_six <= RST_BYTE;
      state.green_filt <= RST_BYTE;
      state.gear <= RST_BYTE;
      state.gain <= RST_BYTE; // see R17
      state.rdata <= RST_WORD;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign o_wb_ack = state.ack;
  assign o_wb_dat = state.rdata;
  assign o_green_sync_filt = state.green_out;
  assign o_gear_low = state.gear_out;
  assign o_cal = state.cal;

endmodule // svcr_regs

//--- test/svcr_regs_checker.sv
// assertion checker for the sync status register bank
module svcr_regs_checker
  import svcr_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [9:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack,
  input wire svcr_pins_t i_pins,
  input wire logic i_auto_offset_en,
  input wire logic o_green_sync_filt,
  input wire logic o_gear_low,
  input wire svcr_cal_t o_cal
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  logic req;
  logic gwr;
  assign req = i_wb_cyc && i_wb_stb;
  assign gwr = req && i_wb_we && i_wb_sel[0] && i_wb_adr[9:2] == IDX_GEAR;
  property p_ack; req && !o_wb_ack |=> o_wb_ack; endproperty
  a_ack: assert property (p_ack) else $error("ack missing");
  property p_pulse; o_wb_ack |=> !o_wb_ack; endproperty
  a_pulse: assert property (p_pulse) else $error("ack too long");
  property p_upper; o_wb_ack |-> o_wb_dat[31:8] == 24'h00_0000; endproperty
  a_upper: assert property (p_upper) else $error("upper data set");
  // the gear output trails the register by one cycle
  property p_gear; gwr && !o_wb_ack ##1 o_wb_ack |=> o_gear_low == $past(i_wb_dat[0], 2);
  endproperty
  a_gear: assert property (p_gear) else $error("gear wrong");
  property p_orun; !i_auto_offset_en |=> !o_cal.offset_run; endproperty
  a_orun: assert property (p_orun) else $error("offset runs");
  property p_oset; $rose(o_cal.offset_settled) |-> o_cal.offset_run; endproperty
  a_oset: assert property (p_oset) else $error("offset settle");
  property p_oclr; !o_cal.offset_run [*2] |-> !o_cal.offset_settled; endproperty
  a_oclr: assert property (p_oclr) else $error("settle kept");
  // two sync flops plus the output flop, so a rise needs the pin high three edges back
  property p_green; $rose(o_green_sync_filt) |-> $past(i_pins.green_sync, 3); endproperty
  a_green: assert property (p_green) else $error("green early");
  c_wr: cover property (gwr ##1 o_wb_ack);
  c_oset: cover property ($rose(o_cal.offset_settled));
  c_gset: cover property ($rose(o_cal.gain_settled));
endmodule // svcr_regs_checker

bind svcr_regs svcr_regs_checker u_svcr_regs_checker (
  .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_wb_cyc(i_wb_cyc),
  .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel),
  .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_pins(i_pins),
  .i_auto_offset_en(i_auto_offset_en), .o_green_sync_filt(o_green_sync_filt),
  .o_gear_low(o_gear_low), .o_cal(o_cal)
);

//--- test/tb_svcr_regs.sv
// self-checking bench for the sync status register bank
module tb_svcr_regs
  import svcr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [9:0] adr = 10'h000;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic ack, gfilt, gear;
  svcr_pins_t pins = '0;
  logic ssel = 1'b0, aen = 1'b0, oup = 1'b0, gup = 1'b0;
  svcr_cal_t cal;
  int num_errors = 0, total_checks = 0;
  logic [7:0] q, d;
  logic [11:0] n, m, e;
  logic [7:0] rw [8] = '{8'h28, 8'h29, 8'h2c, 8'h2d, 8'h2e, 8'h34, 8'h36, 8'h3c};
  logic [7:0] rv [8] = '{8'hbf, 8'h02, 8'h00, 8'he8, 8'he0, 8'h00, 8'h00, 8'h00};
  // bits the host must keep zero stay zero even in random writes
  logic [7:0] rm [8] = '{8'hff, 8'hff, 8'h10, 8'hff, 8'hff, 8'hff, 8'hff, 8'h0f};
  logic [7:0] ro [6] = '{8'h25, 8'h26, 8'h27, 8'h2a, 8'h2b, 8'h30};
  always #50 clk = ~clk;
  svcr_regs u_svcr_regs (
    .i_core_clk(clk), .i_sys_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_pins(pins), .i_sync_input_sel(ssel), .i_auto_offset_en(aen), .i_offset_update(oup),
    .i_gain_update(gup), .o_green_sync_filt(gfilt), .o_gear_low(gear), .o_cal(cal)
  );
  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk_reg(input logic [7:0] x, input logic [7:0] g);
    total_checks++;
    if (g !== x)
    begin
      num_errors++;
      $display("ERROR %0t reg exp %h got %h", $time, x, g);
    end
  endtask
  task automatic chk_out(input logic x, input logic g);
    total_checks++;
    if (g !== x)
    begin
      num_errors++;
      $display("ERROR %0t out exp %h got %h", $time, x, g);
    end
  endtask
  // one classic cycle; held until ack is sampled, then released for a cycle
  task automatic wb(input logic w, input logic [7:0] i, input logic [7:0] v);
    int c;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {i, 2'b00};
    sel <= 4'h1;
    wdat <= {24'h00_0000, v};
    c = 0;
    do
    begin
      @(posedge clk);
      c++;
    end
    while (ack !== 1'b1 && c < 20);
    if (ack !== 1'b1)
    begin
      num_errors++;
      end_sim;
    end
    else
    begin
      q = rdat[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
    end
  endtask
  // a raw and b regenerated hsync pulses, then a vsync pulse closes the frame
  task automatic frame(input logic [11:0] a, input logic [11:0] b);
    for (int k = 0; k < 400; k++)
    begin
      pins.hsync_raw <= k[1] && k < 4 * a;
      pins.hsync_regen <= k[1] && k < 4 * b;
      @(posedge clk);
    end
    pins.vsync <= 1'b1;
    repeat (3) @(posedge clk);
    pins.vsync <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic green(input logic en, input int w, input logic x);
    logic hit;
    hit = 1'b0;
    wb(1'b1, IDX_GREEN_FILT, {5'h00, en, 2'h0});
    for (int k = 0; k < w + 8; k++)
    begin
      pins.green_sync <= k < w;
      @(posedge clk);
      hit |= gfilt;
    end
    chk_out(x, hit);
  endtask
  task automatic upd(input logic o, input logic g, input int c);
    repeat (c)
    begin
      oup <= o;
      gup <= g;
      @(posedge clk);
      oup <= 1'b0;
      gup <= 1'b0;
      @(posedge clk);
    end
    repeat (2) @(posedge clk);
  endtask
  initial
  begin
    d = 8'($urandom(92));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    foreach (rw[k])
    begin
      wb(1'b0, rw[k], 8'h00);
      chk_reg(8'h00, q);
      d = 8'($urandom) & rm[k];
      wb(1'b1, rw[k], d);
      wb(1'b0, rw[k], 8'h00);
      chk_reg(d, q);
      wb(1'b1, rw[k], rv[k]);
      wb(1'b0, rw[k], 8'h00);
      chk_reg(rv[k], q);
    end
    // nothing has reached the status inputs yet, so every read-only place reads zero
    foreach (ro[k])
    begin
      wb(1'b1, ro[k], 8'($urandom));
      wb(1'b0, ro[k], 8'h00);
      chk_reg(8'h00, q);
    end
    for (int k = 0; k < 6; k++)
    begin
      d = (k == 0) ? 8'h0f : (k == 5) ? 8'h00 : 8'($urandom);
      {pins.coast_pol, pins.clamp_pol, pins.extra_pulse, pins.filt_lock} <= d[3:0];
      repeat (4) @(posedge clk);
      wb(1'b0, IDX_STATUS, 8'h00);
      chk_reg({4'h0, d[3:0]}, q);
    end
    frame(12'h000, 12'h000);
    for (int k = 0; k < 4; k++)
    begin
      n = (k == 0) ? 12'h010 : 12'($urandom_range(1, 99));
      m = 12'($urandom_range(1, 99));
      ssel <= k[0];
      frame(n, m);
      e = k[0] ? m : n;
      wb(1'b0, IDX_CNT_UPPER, 8'h00);
      chk_reg(e[11:4], q);
      wb(1'b0, IDX_CNT_LOWER, 8'h00);
      chk_reg({e[3:0], 4'h0}, q);
    end
    for (int k = 1; k >= 0; k--)
    begin
      wb(1'b1, IDX_GEAR, 8'(k));
      @(posedge clk);
      chk_out(k[0], gear);
    end
    green(1'b0, 1, 1'b1);
    green(1'b1, 2, 1'b0);
    green(1'b1, 3, 1'b1);
    aen <= 1'b1;
    wb(1'b1, IDX_OFFSET_HOLD, 8'h00);
    chk_out(1'b1, cal.offset_run);
    upd(1'b1, 1'b0, 9);
    chk_out(1'b0, cal.offset_settled);
    upd(1'b1, 1'b0, 1);
    chk_out(1'b1, cal.offset_settled);
    wb(1'b1, IDX_OFFSET_HOLD, 8'h10);
    chk_out(1'b0, cal.offset_run);
    // a mode change calls for another one-time offset update
    ssel <= ~ssel;
    wb(1'b1, IDX_OFFSET_HOLD, 8'h00);
    upd(1'b1, 1'b0, 10);
    chk_out(1'b1, cal.offset_settled);
    wb(1'b1, IDX_OFFSET_HOLD, 8'h10);
    chk_out(1'b0, cal.offset_settled);
    for (int k = 0; k < 8; k++)
    begin
      wb(1'b1, IDX_GAIN, 8'(k + 8));
      chk_out(k == 6, cal.gain_run);
    end
    wb(1'b1, IDX_GAIN, 8'h06);
    chk_out(1'b0, cal.gain_run);
    wb(1'b1, IDX_GAIN, 8'h0e);
    upd(1'b0, 1'b1, 10);
    chk_out(1'b1, cal.gain_settled);
    wb(1'b1, IDX_GAIN, 8'h06);
    chk_out(1'b0, cal.gain_settled);
    end_sim;
  end
endmodule // tb_svcr_regs
